//--- hdl/adc_channel_cal_regs.sv
// Purpose: channel 4 setup and calibration register bank
// Assumes: one clock, plain register port, read data one cycle after strobe
// Notes: channel 5 setup is held here too, datapath lives elsewhere
// Function
// - the 10-bit phase field is a signed delay in modulator clock cycles for channel 4.
// - bypass bit 0 follows the global dc filter setting, 1 turns the filter off for this channel.
// - selector 00 picks the channel's own pair and 01 shorts the converter inputs.
// - selector 10 applies the positive dc test signal and 11 the negative one.
// - the upper offset register gives offset bits 23 to 8, two's complement.
// - the lower offset register keeps offset bits 7 to 0 in its upper byte, low byte read-only.
// - the upper gain register gives gain bits 23 to 8 and resets to unity gain.
// - the lower gain register keeps gain bits 7 to 0 in its upper byte, low byte read-only.
// - the gain word is unsigned, 0.0 to just under 2.0 in steps of 2^-23.
// - the upper offset register resets to zero.
// - the lower offset register resets to zero.
// - channel 5 setup sits at the next address after lower gain and resets to zero.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module adc_channel_cal_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic global_dc_filter_setting,
  output logic signed [9:0] ch4_phase_delay,
  output logic ch4_hpf_enable,
  output logic ch4_pos_input,
  output logic ch4_neg_input,
  output logic ch4_inputs_shorted,
  output logic ch4_test_pos,
  output logic ch4_test_neg,
  output logic signed [23:0] ch4_offset_cal,
  output logic [23:0] ch4_gain_cal,
  output logic [15:0] ch5_channel_setup
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] ch4_channel_setup;
    logic [15:0] ch4_offset_cal_high;
    logic [15:0] ch4_offset_cal_low;
    logic [15:0] ch4_gain_cal_high;
    logic [15:0] ch4_gain_cal_low;
    logic [15:0] ch5_channel_setup;
    logic [15:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [23:0] offset_word;
  logic [23:0] gain_word;
  logic own_pair;

  // masked write: reserved positions never take a one
  function automatic logic [15:0] masked_write(input logic [15:0] wdata, input logic [15:0] wmask);
    masked_write = wdata & wmask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    if (reg_wr) begin
      case (reg_addr)
        ch_cal_pkg::ch4_channel_setup_addr:
          st_nxt.ch4_channel_setup = masked_write(reg_wdata, ch_cal_pkg::setup_wmask);
        ch_cal_pkg::ch4_offset_cal_high_addr:
          st_nxt.ch4_offset_cal_high = reg_wdata;
        ch_cal_pkg::ch4_offset_cal_low_addr:
          st_nxt.ch4_offset_cal_low = masked_write(reg_wdata, ch_cal_pkg::low_wmask);
        ch_cal_pkg::ch4_gain_cal_high_addr:
          st_nxt.ch4_gain_cal_high = reg_wdata;
        ch_cal_pkg::ch4_gain_cal_low_addr:
          st_nxt.ch4_gain_cal_low = masked_write(reg_wdata, ch_cal_pkg::low_wmask);
        ch_cal_pkg::ch5_channel_setup_addr:
          st_nxt.ch5_channel_setup = masked_write(reg_wdata, ch_cal_pkg::setup_wmask);
        default: begin
        end
      endcase
    end
    // read data stands only in the cycle after the strobe; unmapped reads zero
    st_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ch_cal_pkg::ch4_channel_setup_addr: st_nxt.rdata = st_r.ch4_channel_setup;
        ch_cal_pkg::ch4_offset_cal_high_addr: st_nxt.rdata = st_r.ch4_offset_cal_high;
        ch_cal_pkg::ch4_offset_cal_low_addr: st_nxt.rdata = st_r.ch4_offset_cal_low;
        ch_cal_pkg::ch4_gain_cal_high_addr: st_nxt.rdata = st_r.ch4_gain_cal_high;
        ch_cal_pkg::ch4_gain_cal_low_addr: st_nxt.rdata = st_r.ch4_gain_cal_low;
        ch_cal_pkg::ch5_channel_setup_addr: st_nxt.rdata = st_r.ch5_channel_setup;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r.ch4_channel_setup <= ch_cal_pkg::ch4_channel_setup_rst;
      st_r.ch4_offset_cal_high <= ch_cal_pkg::ch4_offset_cal_high_rst;
      st_r.ch4_offset_cal_low <= ch_cal_pkg::ch4_offset_cal_low_rst;
      st_r.ch4_gain_cal_high <= ch_cal_pkg::ch4_gain_cal_high_rst;
      st_r.ch4_gain_cal_low <= ch_cal_pkg::ch4_gain_cal_low_rst;
      st_r.ch5_channel_setup <= ch_cal_pkg::ch5_channel_setup_rst;
      st_r.rdata <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ch_setup_decode u_ch4_decode (
    .setup_word(st_r.ch4_channel_setup),
    .global_dc_filter_setting(global_dc_filter_setting),
    .phase_delay(ch4_phase_delay),
    .hpf_enable(ch4_hpf_enable),
    .sel_own_pair(own_pair),
    .sel_shorted(ch4_inputs_shorted),
    .sel_test_pos(ch4_test_pos),
    .sel_test_neg(ch4_test_neg)
  );

  cal_word_join u_offset_join (
    .upper_reg(st_r.ch4_offset_cal_high),
    .lower_reg(st_r.ch4_offset_cal_low),
    .cal_word(offset_word)
  );

  cal_word_join u_gain_join (
    .upper_reg(st_r.ch4_gain_cal_high),
    .lower_reg(st_r.ch4_gain_cal_low),
    .cal_word(gain_word)
  );

  always_comb begin
    reg_rdata = st_r.rdata;
    // both halves of the own pair connect together
    ch4_pos_input = own_pair;
    ch4_neg_input = own_pair;
    ch4_offset_cal = signed'(offset_word);
    // unsigned q1.23: 0x800000 is unity
    ch4_gain_cal = gain_word;
    ch5_channel_setup = st_r.ch5_channel_setup;
  end
endmodule

//--- hdl/ch_cal_pkg.sv
// Purpose: constants for the channel 4 setup and calibration register bank
// Assumes: 16-bit registers on a plain address/strobe port, word addresses
// Notes: channel setup of channel 4 sits at 0x1d, just below the offset pair
package ch_cal_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CAL_W = 24;
  localparam int PHASE_W = 10;

  localparam logic [7:0] ch4_channel_setup_addr = 8'h1d;
  localparam logic [7:0] ch4_offset_cal_high_addr = 8'h1e;
  localparam logic [7:0] ch4_offset_cal_low_addr = 8'h1f;
  localparam logic [7:0] ch4_gain_cal_high_addr = 8'h20;
  localparam logic [7:0] ch4_gain_cal_low_addr = 8'h21;
  localparam logic [7:0] ch5_channel_setup_addr = 8'h22;

  localparam logic [15:0] ch4_channel_setup_rst = 16'h0000;
  localparam logic [15:0] ch4_offset_cal_high_rst = 16'h0000;
  localparam logic [15:0] ch4_offset_cal_low_rst = 16'h0000;
  localparam logic [15:0] ch4_gain_cal_high_rst = 16'h8000;
  localparam logic [15:0] ch4_gain_cal_low_rst = 16'h0000;
  localparam logic [15:0] ch5_channel_setup_rst = 16'h0000;

  // setup register fields
  localparam int PHASE_LSB = 6;
  localparam int PHASE_MSB = 15;
  localparam int BYPASS_BIT = 2;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  // writable bits; reserved bits stay zero
  localparam logic [15:0] setup_wmask = 16'hffc7;
  localparam logic [15:0] low_wmask = 16'hff00;

  typedef enum logic [1:0] {
    SEL_OWN_PAIR = 2'b00,
    SEL_SHORTED = 2'b01,
    SEL_TEST_POS = 2'b10,
    SEL_TEST_NEG = 2'b11
  } input_sel_e;
endpackage

//--- hdl/ch_setup_decode.sv
// Purpose: turn a channel setup word into the channel's control outputs
// Assumes: purely combinational, fed from register flops
// Notes: instanced once, for the channel 4 setup register only; channel 5 setup has no instance here
`timescale 1ns/10ps
module ch_setup_decode (
  input wire logic [15:0] setup_word,
  input wire logic global_dc_filter_setting,
  output logic signed [9:0] phase_delay,
  output logic hpf_enable,
  output logic sel_own_pair,
  output logic sel_shorted,
  output logic sel_test_pos,
  output logic sel_test_neg
);
  ch_cal_pkg::input_sel_e sel;

  always_comb begin
    // signed delay in modulator clock cycles
    phase_delay = signed'(setup_word[ch_cal_pkg::PHASE_MSB:ch_cal_pkg::PHASE_LSB]);
    // bypass set: filter off for this channel only, else follow global
    hpf_enable = !setup_word[ch_cal_pkg::BYPASS_BIT] && global_dc_filter_setting;
    sel = ch_cal_pkg::input_sel_e'(setup_word[ch_cal_pkg::SEL_MSB:ch_cal_pkg::SEL_LSB]);
    sel_own_pair = 1'b0;
    sel_shorted = 1'b0;
    sel_test_pos = 1'b0;
    sel_test_neg = 1'b0;
    case (sel)
      ch_cal_pkg::SEL_OWN_PAIR: sel_own_pair = 1'b1;
      ch_cal_pkg::SEL_SHORTED: sel_shorted = 1'b1;
      ch_cal_pkg::SEL_TEST_POS: sel_test_pos = 1'b1;
      ch_cal_pkg::SEL_TEST_NEG: sel_test_neg = 1'b1;
      default: sel_own_pair = 1'b1;
    endcase
  end
endmodule

//--- hdl/cal_word_join.sv
// Purpose: join an upper and a lower calibration register into one word
// Assumes: lower register carries its bits in the upper byte
// Notes: used for both offset and gain
`timescale 1ns/10ps
module cal_word_join (
  input wire logic [15:0] upper_reg,
  input wire logic [15:0] lower_reg,
  output logic [23:0] cal_word
);
  always_comb begin
    cal_word = {upper_reg, lower_reg[15:8]};
  end
endmodule

//--- bench/adc_channel_cal_regs_checker.sv
// Purpose: port assertions for the channel 4 register bank
// Assumes: one clock, one-cycle strobes, writes land one cycle later
// Notes: bound into the bank, sees its ports only
`timescale 1ns/10ps
module adc_cal_regs_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic global_dc_filter_setting,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] ch5_channel_setup,
  input wire logic signed [9:0] ch4_phase_delay,
  input wire logic ch4_hpf_enable,
  input wire logic ch4_pos_input,
  input wire logic ch4_neg_input,
  input wire logic ch4_inputs_shorted,
  input wire logic ch4_test_pos,
  input wire logic ch4_test_neg,
  input wire logic signed [23:0] ch4_offset_cal,
  input wire logic [23:0] ch4_gain_cal
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_phase_write: assert property (s_wr(8'h1d) |=> ch4_phase_delay == $past(reg_wdata[15:6]))
    else $error("phase field wrong");
  a_hpf_gate: assert property (s_wr(8'h1d) |=>
    ch4_hpf_enable == (!$past(reg_wdata[2]) && global_dc_filter_setting)) else $error("filter enable wrong");
  a_sel_decode: assert property (s_wr(8'h1d) |=> ch4_pos_input == ch4_neg_input &&
    {ch4_test_neg, ch4_test_pos, ch4_inputs_shorted, ch4_neg_input} == 4'h1 << $past(reg_wdata[1:0]))
    else $error("input select decode wrong");
  a_offset_high: assert property (s_wr(8'h1e) |=> ch4_offset_cal[23:8] == $past(reg_wdata))
    else $error("offset upper bits wrong");
  a_offset_low: assert property (s_wr(8'h1f) |=> ch4_offset_cal[7:0] == $past(reg_wdata[15:8]))
    else $error("offset lower bits wrong");
  a_gain_high: assert property (s_wr(8'h20) |=> ch4_gain_cal[23:8] == $past(reg_wdata))
    else $error("gain upper bits wrong");
  a_gain_low: assert property (s_wr(8'h21) |=> ch4_gain_cal[7:0] == $past(reg_wdata[15:8]))
    else $error("gain lower bits wrong");
  a_next_setup: assert property (s_wr(8'h22) |=> ch5_channel_setup == ($past(reg_wdata) & 16'hffc7))
    else $error("next setup register wrong");
  a_unmapped_read: assert property (reg_rd && (reg_addr < 8'h1d || reg_addr > 8'h22) |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  // read data must not linger past its one cycle
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_low_reserved: assert property (reg_rd && (reg_addr == 8'h1f || reg_addr == 8'h21) |=>
    reg_rdata[7:0] == 8'h00) else $error("reserved low byte not zero");
  a_setup_reserved: assert property (reg_rd && (reg_addr == 8'h1d || reg_addr == 8'h22) |=>
    reg_rdata[5:3] == 3'b000) else $error("reserved setup bits not zero");
  a_reset_values: assert property ($rose(rstn) |-> ch4_gain_cal == 24'h800000 &&
    ch4_offset_cal == 24'h000000 && ch5_channel_setup == 16'h0000 && ch4_phase_delay == 10'h000)
    else $error("values after reset wrong");
endmodule
bind adc_channel_cal_regs adc_cal_regs_checker chk_u (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .global_dc_filter_setting(global_dc_filter_setting),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .ch5_channel_setup(ch5_channel_setup),
  .ch4_phase_delay(ch4_phase_delay),
  .ch4_hpf_enable(ch4_hpf_enable),
  .ch4_pos_input(ch4_pos_input),
  .ch4_neg_input(ch4_neg_input),
  .ch4_inputs_shorted(ch4_inputs_shorted),
  .ch4_test_pos(ch4_test_pos),
  .ch4_test_neg(ch4_test_neg),
  .ch4_offset_cal(ch4_offset_cal),
  .ch4_gain_cal(ch4_gain_cal)
);

//--- bench/adc_channel_cal_regs_tb.sv
// Purpose: directed bench for the channel 4 register bank
// Assumes: read data valid only in the cycle after the strobe
// Notes: outputs judged at the falling edge, away from updates
`timescale 1ns/10ps
module adc_channel_cal_regs_tb;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, global_dc_filter_setting = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, ch5_channel_setup;
  logic signed [9:0] ch4_phase_delay;
  logic ch4_hpf_enable, ch4_pos_input, ch4_neg_input, ch4_inputs_shorted, ch4_test_pos, ch4_test_neg;
  logic signed [23:0] ch4_offset_cal;
  logic [23:0] ch4_gain_cal;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  adc_channel_cal_regs dut_u (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .global_dc_filter_setting(global_dc_filter_setting),
    .ch4_phase_delay(ch4_phase_delay),
    .ch4_hpf_enable(ch4_hpf_enable),
    .ch4_pos_input(ch4_pos_input),
    .ch4_neg_input(ch4_neg_input),
    .ch4_inputs_shorted(ch4_inputs_shorted),
    .ch4_test_pos(ch4_test_pos),
    .ch4_test_neg(ch4_test_neg),
    .ch4_offset_cal(ch4_offset_cal),
    .ch4_gain_cal(ch4_gain_cal),
    .ch5_channel_setup(ch5_channel_setup)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic ck(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // callers enter at a rising edge; one idle edge keeps the strobe from two assignments in a step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    ck("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    @(posedge clk_sys);
  endtask
  function automatic logic [23:0] sel_bits();
    return {19'h0, ch4_test_neg, ch4_test_pos, ch4_inputs_shorted, ch4_neg_input, ch4_pos_input};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge clk_sys);
    ck("gain", ch4_gain_cal, 24'h800000);
    ck("offset", ch4_offset_cal, 24'h000000);
    ck("select", sel_bits(), 24'h000003);
    @(posedge clk_sys);
    rd(8'h1d, 16'h0000);
    rd(8'h1e, 16'h0000);
    rd(8'h1f, 16'h0000);
    rd(8'h20, 16'h8000);
    rd(8'h21, 16'h0000);
    rd(8'h22, 16'h0000);
  endtask
  // every selector code, bypass toggled, reserved bits written as ones
  task automatic t_setup;
    for (int i = 0; i < 4; i++) begin
      wr(8'h1d, {10'h200 + 10'(i), 3'b111, i[0], i[1:0]});
      @(negedge clk_sys);
      ck("phase", {14'h0, ch4_phase_delay}, {14'h0, 10'h200 + 10'(i)});
      ck("select", sel_bits(), (i == 0) ? 24'h000003 : 24'h000002 << i);
      ck("hpf", {23'h0, ch4_hpf_enable}, {23'h0, !i[0]});
      @(posedge clk_sys);
      rd(8'h1d, {10'h200 + 10'(i), 3'b000, i[0], i[1:0]});
    end
    global_dc_filter_setting <= 1'b0;
    wr(8'h1d, 16'h0000);
    @(negedge clk_sys);
    ck("hpf", {23'h0, ch4_hpf_enable}, 24'h000000);
    @(posedge clk_sys);
    global_dc_filter_setting <= 1'b1;
  endtask
  task automatic t_cal;
    wr(8'h1e, 16'h8001);
    wr(8'h1f, 16'hfeff);
    wr(8'h20, 16'hffff);
    wr(8'h21, 16'hff5a);
    rd(8'h1f, 16'hfe00);
    rd(8'h21, 16'hff00);
    @(negedge clk_sys);
    ck("offset", ch4_offset_cal, 24'h8001fe);
    ck("gain", ch4_gain_cal, 24'hffffff);
    @(posedge clk_sys);
    wr(8'h1e, 16'h1234);
    rd(8'h1e, 16'h1234);
    wr(8'h23, 16'h0000);
    wr(8'h22, 16'hffff);
    rd(8'h22, 16'hffc7);
    @(negedge clk_sys);
    ck("ch5", {8'h00, ch5_channel_setup}, 24'h00ffc7);
    @(posedge clk_sys);
    rd(8'h23, 16'h0000);
    rd(8'h1c, 16'h0000);
    rd(8'h20, 16'hffff);
  endtask
  // reset in mid-run must bring every register back, not only after power-up
  task automatic t_rerun;
    wr(8'h1d, 16'h8003);
    rstn <= 1'b0;
    @(negedge clk_sys);
    ck("gain", ch4_gain_cal, 24'h800000);
    ck("offset", ch4_offset_cal, 24'h000000);
    ck("phase", {14'h0, ch4_phase_delay}, 24'h000000);
    ck("ch5", {8'h00, ch5_channel_setup}, 24'h000000);
    ck("select", sel_bits(), 24'h000003);
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h1f, 16'h0000);
    rd(8'h21, 16'h0000);
    rd(8'h1d, 16'h0000);
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_setup();
    t_cal();
    t_rerun();
    close_out();
  end
  // whole run is about a hundred cycles
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule
